// ===== tsar_regs.sv
// Purpose: Register, alarm and conversion control of a two-channel sensor
// Assumes: Link logic delivers decoded byte transactions on link_clk
// Notes:   Converter results arrive on sys_clk with a done pulse
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Alert on any limit violation, optional diode fault
// - Alert latched; released by status read or ARA
// - Automatic conversions continue while alert asserted
// - Alert pin only pulls low or floats
// - Alert after queued consecutive faults: 1,2,1,3
// - Pending alert answers alert response with address
// - Arbitration loser keeps alert low, no ack
// - Overheat sets at limit, clears below limit-hysteresis
// - Command byte indexes registers, resets to zero
// - Bus accesses cross domains without corrupting results
// - One-shot starts conversion now, then back to standby
// - One-shot during running one-shot is discarded
// - Autonomous one-shot restarts conversion-rate timer
// - Config bit7 masks alert, bit6 selects standby
// - Status shows thresholds, busy, fault; zero at reset
// - Status read while not busy clears flags whose condition vanished
// - Flag clear alone does not release alert
// - Separate read and write codes; overheat limits RW
// - Status bit order busy down to local overheat
// - High limit violated at equal or above
// - Rate uses three bits, 06h and 07h fastest
module tsar_regs #(
    parameter logic [6:0] OWN_ADDR        = 7'h4c,
    parameter logic [7:0] MAKER_ID        = 8'ha5,  // Arbitrary value
    parameter logic [7:0] REVISION_ID     = 8'h01,  // Arbitrary value
    parameter bit         FAULT_ALERTS    = 1'b0,
    parameter int         INTERVAL_CYCLES = tsar_pkg::FASTEST_INTERVAL_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       link_clk,
    input  wire logic       link_req,
    input  wire logic [2:0] link_kind,
    input  wire logic [7:0] link_cmd,
    input  wire logic [7:0] link_wdata,
    output logic            link_busy,
    output logic            link_done,
    output logic            link_nak,
    output logic      [7:0] link_rdata,
    input  wire logic       conv_done,
    input  wire logic [7:0] local_temp,
    input  wire logic [7:0] local_frac,
    input  wire logic [7:0] remote_temp,
    input  wire logic [7:0] remote_frac,
    input  wire logic       diode_fault,
    output logic            conv_start,
    output logic            conv_abort,
    output logic            alert_o,
    output logic            alert_oe,
    output logic            overheat_out_n_o,
    output logic            overheat_out_n_oe
);
    typedef enum logic [0:0] {TSAR_IDLE, TSAR_BUSY} tsar_conv_e;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    // Fault queue length from the two select bits
    function automatic logic [1:0] queue_len(input logic [7:0] cfg);
        logic [1:0] sel;
        sel = {cfg[tsar_pkg::FQ_SEL_HI_BIT], cfg[tsar_pkg::FQ_SEL_LO_BIT]};
        case (sel)
            2'b01:   queue_len = 2'd2;
            2'b11:   queue_len = 2'd3;
            default: queue_len = 2'd1;
        endcase
    endfunction

    // Interval in cycles; rates above the fastest code saturate
    function automatic logic [31:0] rate_cycles(input logic [2:0] code);
        logic [2:0] sh;
        sh = (code >= 3'(tsar_pkg::RATE_FASTEST)) ? 3'd0 : 3'(tsar_pkg::RATE_FASTEST) - code;
        rate_cycles = 32'(INTERVAL_CYCLES) << sh;
    endfunction

    // ********************************************************************
    // Link domain: capture and handshake
    // ********************************************************************
    logic       lk_pend;
    logic       lk_req_tgl;
    logic [2:0] lk_kind;
    logic [7:0] lk_cmd;
    logic [7:0] lk_wdata;
    logic       lk_ack_s1;
    logic       lk_ack_s2;
    logic       lk_ack_s3;
    logic       sy_ack_tgl;
    logic [7:0] sy_rdata;
    logic       sy_nak;

    wire lk_take = link_req && !lk_pend && !link_done;  // Held request is not retaken in the answer cycle
    wire lk_ack  = lk_ack_s2 ^ lk_ack_s3;

    // Fields stay frozen while pending so the far side may sample them
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            lk_pend    <= 1'b0;
            lk_req_tgl <= 1'b0;
            lk_kind    <= 3'h0;
            lk_cmd     <= 8'h00;
            lk_wdata   <= 8'h00;
        end else if (lk_take) begin
            lk_pend    <= 1'b1;
            lk_req_tgl <= ~lk_req_tgl;
            lk_kind    <= link_kind;
            lk_cmd     <= link_cmd;
            lk_wdata   <= link_wdata;
        end else if (lk_ack) begin
            lk_pend    <= 1'b0;
        end
    end

    // Answer side of the handshake
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            lk_ack_s1  <= 1'b0;
            lk_ack_s2  <= 1'b0;
            lk_ack_s3  <= 1'b0;
            link_done  <= 1'b0;
            link_nak   <= 1'b0;
            link_rdata <= 8'h00;
            link_busy  <= 1'b0;
        end else begin
            lk_ack_s1  <= sy_ack_tgl;
            lk_ack_s2  <= lk_ack_s1;
            lk_ack_s3  <= lk_ack_s2;
            link_done  <= lk_ack;
            link_busy  <= (lk_pend || lk_take) && !lk_ack;
            if (lk_ack) begin
                link_nak   <= sy_nak;
                link_rdata <= sy_rdata;
            end
        end
    end

    // ********************************************************************
    // System domain: request arrival
    // ********************************************************************
    logic sy_req_s1;
    logic sy_req_s2;
    logic sy_req_s3;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sy_req_s1 <= 1'b0;
            sy_req_s2 <= 1'b0;
            sy_req_s3 <= 1'b0;
        end else begin
            sy_req_s1 <= lk_req_tgl;
            sy_req_s2 <= sy_req_s1;
            sy_req_s3 <= sy_req_s2;
        end
    end

    // ********************************************************************
    // Registers and state
    // ********************************************************************
    logic [7:0] cmd_ptr;
    logic [7:0] cfg_bits;
    logic [7:0] conv_rate;
    logic [7:0] lhi_lim;
    logic [7:0] llo_lim;
    logic [7:0] rhi_lim;
    logic [7:0] rlo_lim;
    logic [7:0] rovh_lim;
    logic [7:0] lovh_lim;
    logic [7:0] ovh_hyst;
    logic [7:0] fq_cfg;
    logic [7:0] lt_int;
    logic [7:0] lt_frac;
    logic [7:0] rt_int;
    logic [7:0] rt_frac;
    logic [4:0] hold_flags;  // lh, ll, rh, rl, diode
    logic [4:0] live_cond;
    logic [1:0] ovh_state;   // remote, local
    logic [1:0] fcnt [4];
    logic       alert_latch;
    logic       one_shot_run;
    logic       start_pend;
    logic [31:0] rate_cnt;
    tsar_conv_e conv_st;

    // ********************************************************************
    // Transaction decode
    // ********************************************************************
    wire       req_new   = sy_req_s2 ^ sy_req_s3;
    wire       is_wr     = req_new && lk_kind == tsar_pkg::KIND_WRITE_BYTE;
    wire       is_rd     = req_new && lk_kind == tsar_pkg::KIND_READ_BYTE;
    wire       is_send   = req_new && lk_kind == tsar_pkg::KIND_SEND_BYTE;
    wire       is_recv   = req_new && lk_kind == tsar_pkg::KIND_RECV_BYTE;
    wire       is_ara    = req_new && lk_kind == tsar_pkg::KIND_ARA;
    wire       is_ara_ok = req_new && lk_kind == tsar_pkg::KIND_ARA_OK;
    wire [7:0] rd_index  = is_recv ? cmd_ptr : lk_cmd;
    wire       wr_cmd    = is_wr || is_send;
    wire       do_write  = is_wr;
    wire       one_shot  = wr_cmd && lk_cmd == tsar_pkg::CMD_ONE_SHOT;
    wire       stat_read = (is_rd || is_recv) && rd_index == tsar_pkg::CMD_STATUS;
    wire       busy      = conv_st == TSAR_BUSY;
    wire       standby   = cfg_bits[tsar_pkg::CFG_STBY_BIT];
    wire       ara_pend  = alert_latch;

    // Status byte, busy on top down to local overheat
    wire [7:0] status_byte = {busy, hold_flags, ovh_state};

    // Read mux; unmapped codes read zero
    logic [7:0] rd_data;
    always_comb begin
        case (rd_index)
            tsar_pkg::CMD_LOCAL_TEMP:  rd_data = lt_int;
            tsar_pkg::CMD_REMOTE_TEMP: rd_data = rt_int;
            tsar_pkg::CMD_STATUS:      rd_data = status_byte;
            tsar_pkg::CMD_CFG_RD:      rd_data = cfg_bits;
            tsar_pkg::CMD_RATE_RD:     rd_data = conv_rate;
            tsar_pkg::CMD_LHI_RD:      rd_data = lhi_lim;
            tsar_pkg::CMD_LLO_RD:      rd_data = llo_lim;
            tsar_pkg::CMD_RHI_RD:      rd_data = rhi_lim;
            tsar_pkg::CMD_RLO_RD:      rd_data = rlo_lim;
            tsar_pkg::CMD_REMOTE_FRAC: rd_data = rt_frac;
            tsar_pkg::CMD_LOCAL_FRAC:  rd_data = lt_frac;
            tsar_pkg::CMD_REMOTE_OVH:  rd_data = rovh_lim;
            tsar_pkg::CMD_LOCAL_OVH:   rd_data = lovh_lim;
            tsar_pkg::CMD_OVH_HYST:    rd_data = ovh_hyst;
            tsar_pkg::CMD_FAULT_CNT:   rd_data = fq_cfg;
            tsar_pkg::CMD_MAKER:       rd_data = MAKER_ID;
            tsar_pkg::CMD_REVISION:    rd_data = REVISION_ID;
            default:                   rd_data = 8'h00;
        endcase
    end

    // Answer toward link; ARA without pending alert is not acknowledged
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sy_ack_tgl <= 1'b0;
            sy_rdata   <= 8'h00;
            sy_nak     <= 1'b0;
        end else if (req_new) begin
            sy_ack_tgl <= ~sy_ack_tgl;
            sy_rdata   <= is_ara ? {OWN_ADDR, 1'b1} : rd_data;
            sy_nak     <= is_ara && !ara_pend;
        end
    end

    // Command pointer and writable registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_ptr   <= tsar_pkg::RST_CMD_PTR;
            cfg_bits  <= 8'h00;
            conv_rate <= tsar_pkg::RST_RATE;
            lhi_lim   <= tsar_pkg::RST_LHI;
            llo_lim   <= tsar_pkg::RST_LLO;
            rhi_lim   <= tsar_pkg::RST_RHI;
            rlo_lim   <= tsar_pkg::RST_RLO;
            rovh_lim  <= tsar_pkg::RST_REMOTE_OVH;
            lovh_lim  <= tsar_pkg::RST_LOCAL_OVH;
            ovh_hyst  <= tsar_pkg::RST_OVH_HYST;
            fq_cfg    <= tsar_pkg::RST_FAULT_CNT;
        end else begin
            if (wr_cmd || is_rd) begin
                cmd_ptr <= lk_cmd;
            end
            if (do_write) begin
                case (lk_cmd)
                    tsar_pkg::CMD_CFG_WR:     cfg_bits  <= lk_wdata & 8'hc0;
                    tsar_pkg::CMD_RATE_WR:    conv_rate <= lk_wdata;
                    tsar_pkg::CMD_LHI_WR:     lhi_lim   <= lk_wdata;
                    tsar_pkg::CMD_LLO_WR:     llo_lim   <= lk_wdata;
                    tsar_pkg::CMD_RHI_WR:     rhi_lim   <= lk_wdata;
                    tsar_pkg::CMD_RLO_WR:     rlo_lim   <= lk_wdata;
                    tsar_pkg::CMD_REMOTE_OVH: rovh_lim  <= lk_wdata;
                    tsar_pkg::CMD_LOCAL_OVH:  lovh_lim  <= lk_wdata;
                    tsar_pkg::CMD_OVH_HYST:   ovh_hyst  <= lk_wdata;
                    tsar_pkg::CMD_FAULT_CNT:  fq_cfg    <= lk_wdata;
                    default:                  cmd_ptr   <= lk_cmd;
                endcase
            end
        end
    end

    // ********************************************************************
    // Conversion sequencing
    // ********************************************************************
    wire [31:0] interval  = rate_cycles(conv_rate[2:0]);
    wire        timer_hit = rate_cnt >= interval - 32'd1;
    wire        os_accept = one_shot && !one_shot_run;
    wire        auto_go   = !standby && !busy && (start_pend || timer_hit);
    wire        start_now = os_accept || auto_go;
    wire        truncate  = standby && busy && !one_shot_run && !os_accept;
    wire        result_ok = conv_done && busy;

    // Any start restarts the rate timer, so a full interval follows
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_st      <= TSAR_IDLE;
            one_shot_run <= 1'b0;
            start_pend   <= 1'b1;
            rate_cnt     <= 32'd0;
            conv_start   <= 1'b0;
            conv_abort   <= 1'b0;
        end else begin
            conv_start <= start_now;
            conv_abort <= truncate;
            if (start_now || standby) begin
                rate_cnt <= 32'd0;
            end else if (!timer_hit) begin
                rate_cnt <= rate_cnt + 32'd1;
            end
            if (start_now) begin
                start_pend <= 1'b0;
            end
            case (conv_st)
                TSAR_IDLE: begin
                    if (start_now) begin
                        conv_st      <= TSAR_BUSY;
                        one_shot_run <= os_accept;
                    end
                end
                TSAR_BUSY: begin
                    if (os_accept) begin
                        one_shot_run <= 1'b1;
                    end else if (truncate || result_ok) begin
                        conv_st      <= TSAR_IDLE;
                        one_shot_run <= 1'b0;
                    end
                end
                default: conv_st <= TSAR_IDLE;
            endcase
        end
    end

    // ********************************************************************
    // Limit evaluation
    // ********************************************************************
    wire [3:0] viol = {remote_temp < rlo_lim, remote_temp >= rhi_lim,
                       local_temp < llo_lim, local_temp >= lhi_lim};
    wire [1:0] qlen = queue_len(fq_cfg);
    logic [1:0] next_fcnt [4];
    logic [3:0] tripped;

    // Saturating consecutive counters, one per limit
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_fcnt[i] = !viol[i] ? 2'd0 : (fcnt[i] == 2'd3) ? 2'd3 : fcnt[i] + 2'd1;
            tripped[i]   = result_ok && next_fcnt[i] >= qlen;
        end
    end

    // Hysteresis floors, widened so a small limit does not wrap
    wire [8:0] lovh_floor = {1'b0, lovh_lim} - {1'b0, ovh_hyst};
    wire [8:0] rovh_floor = {1'b0, rovh_lim} - {1'b0, ovh_hyst};
    wire       l_ovh_set  = local_temp >= lovh_lim;
    wire       r_ovh_set  = remote_temp >= rovh_lim;
    wire       l_ovh_clr  = !lovh_floor[8] && {1'b0, local_temp} < lovh_floor;
    wire       r_ovh_clr  = !rovh_floor[8] && {1'b0, remote_temp} < rovh_floor;
    wire [4:0] set_flags  = {tripped[0], tripped[1], tripped[2], tripped[3],
                             result_ok && diode_fault};
    wire       clr_ok     = !busy;
    wire       any_trip   = |tripped || (FAULT_ALERTS && result_ok && diode_fault);
    wire       any_cond   = |live_cond[4:1] || (FAULT_ALERTS && live_cond[0]);
    wire       release_ok = (stat_read || is_ara_ok) && !any_cond;

    // Results, counters and overheat state update only on accepted results
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lt_int    <= 8'h00;
            lt_frac   <= 8'h00;
            rt_int    <= 8'h00;
            rt_frac   <= 8'h00;
            live_cond <= 5'h00;
            ovh_state <= 2'b00;
            for (int i = 0; i < 4; i++) begin
                fcnt[i] <= 2'd0;
            end
        end else if (result_ok) begin
            lt_int    <= local_temp;
            lt_frac   <= local_frac;
            rt_int    <= diode_fault ? 8'hff : remote_temp;
            rt_frac   <= remote_frac;
            live_cond <= {viol[0], viol[1], viol[2], viol[3], diode_fault};
            for (int i = 0; i < 4; i++) begin
                fcnt[i] <= next_fcnt[i];
            end
            ovh_state[1] <= r_ovh_set || (ovh_state[1] && !r_ovh_clr);
            ovh_state[0] <= l_ovh_set || (ovh_state[0] && !l_ovh_clr);
        end
    end

    // Sticky flags; a new trip wins over a clearing status read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_flags <= 5'h00;
        end else begin
            hold_flags <= set_flags |
                          (hold_flags & ~((stat_read && clr_ok) ? ~live_cond : 5'h00));
        end
    end

    // ********************************************************************
    // Alarm pins
    // ********************************************************************
    // Latch set wins over release in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_latch <= 1'b0;
        end else if (any_trip) begin
            alert_latch <= 1'b1;
        end else if (release_ok) begin
            alert_latch <= 1'b0;
        end
    end

    // Open drain: data stays low, only the enable moves
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_o           <= 1'b0;
            alert_oe          <= 1'b0;
            overheat_out_n_o  <= 1'b0;
            overheat_out_n_oe <= 1'b0;
        end else begin
            alert_o           <= 1'b0;
            alert_oe          <= alert_latch && !cfg_bits[tsar_pkg::CFG_MASK_BIT];
            overheat_out_n_o  <= 1'b0;
            overheat_out_n_oe <= |ovh_state;
        end
    end
endmodule
`default_nettype wire

// ===== tsar_pkg.sv
// Purpose: Shared constants for the temperature sensor alarm register bank
// Assumes: 50 MHz system clock, byte-wide registers indexed by a command byte
// Notes:   Offsets are command-byte codes, not bus byte addresses
`default_nettype none
package tsar_pkg;
    // ********************************************************************
    // Command codes
    // ********************************************************************
    localparam logic [7:0] CMD_LOCAL_TEMP     = 8'h00;
    localparam logic [7:0] CMD_REMOTE_TEMP    = 8'h01;
    localparam logic [7:0] CMD_STATUS         = 8'h02;
    localparam logic [7:0] CMD_CFG_RD         = 8'h03;
    localparam logic [7:0] CMD_RATE_RD        = 8'h04;
    localparam logic [7:0] CMD_LHI_RD         = 8'h05;
    localparam logic [7:0] CMD_LLO_RD         = 8'h06;
    localparam logic [7:0] CMD_RHI_RD         = 8'h07;
    localparam logic [7:0] CMD_RLO_RD         = 8'h08;
    localparam logic [7:0] CMD_CFG_WR         = 8'h09;
    localparam logic [7:0] CMD_RATE_WR        = 8'h0a;
    localparam logic [7:0] CMD_LHI_WR         = 8'h0b;
    localparam logic [7:0] CMD_LLO_WR         = 8'h0c;
    localparam logic [7:0] CMD_RHI_WR         = 8'h0d;
    localparam logic [7:0] CMD_RLO_WR         = 8'h0e;
    localparam logic [7:0] CMD_ONE_SHOT       = 8'h0f;
    localparam logic [7:0] CMD_REMOTE_FRAC    = 8'h10;
    localparam logic [7:0] CMD_LOCAL_FRAC     = 8'h11;
    localparam logic [7:0] CMD_REMOTE_OVH     = 8'h19;
    localparam logic [7:0] CMD_LOCAL_OVH      = 8'h20;
    localparam logic [7:0] CMD_OVH_HYST       = 8'h21;
    localparam logic [7:0] CMD_FAULT_CNT      = 8'h22;
    localparam logic [7:0] CMD_MAKER          = 8'hfe;
    localparam logic [7:0] CMD_REVISION       = 8'hff;
    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] RST_CMD_PTR        = 8'h00;
    localparam logic [7:0] RST_RATE           = 8'h07;
    localparam logic [7:0] RST_LHI            = 8'h55;
    localparam logic [7:0] RST_LLO            = 8'h00;
    localparam logic [7:0] RST_RHI            = 8'h5f;
    localparam logic [7:0] RST_RLO            = 8'h00;
    localparam logic [7:0] RST_REMOTE_OVH     = 8'h7d;
    localparam logic [7:0] RST_LOCAL_OVH      = 8'h55;
    localparam logic [7:0] RST_OVH_HYST       = 8'h0a;
    localparam logic [7:0] RST_FAULT_CNT      = 8'h86;
    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int CFG_MASK_BIT  = 7;
    localparam int CFG_STBY_BIT  = 6;
    localparam int FQ_SEL_HI_BIT = 2;
    localparam int FQ_SEL_LO_BIT = 1;
    localparam int RATE_FASTEST  = 6;
    // ********************************************************************
    // Link request kinds
    // ********************************************************************
    localparam logic [2:0] KIND_WRITE_BYTE = 3'h0;
    localparam logic [2:0] KIND_READ_BYTE  = 3'h1;
    localparam logic [2:0] KIND_SEND_BYTE  = 3'h2;
    localparam logic [2:0] KIND_RECV_BYTE  = 3'h3;
    localparam logic [2:0] KIND_ARA        = 3'h4;
    localparam logic [2:0] KIND_ARA_OK     = 3'h5;
    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int SYS_CLK_HZ              = 50_000_000;
    localparam int FASTEST_INTERVAL_MS     = 250;
    localparam int FASTEST_INTERVAL_CYCLES = SYS_CLK_HZ / 1000 * FASTEST_INTERVAL_MS;
endpackage
`default_nettype wire

// ===== tsar_regs_chk.sv
// Purpose: Port-level timing checks for the sensor register bank
// Assumes: Link and system domains share the async reset_n
// Notes:   Watches only what the design drives
`timescale 1ns/1ns
`default_nettype none
module tsar_regs_chk (
    input wire logic       sys_clk, reset_n, link_clk, link_busy, link_done, link_nak,
    input wire logic [7:0] link_rdata,
    input wire logic       conv_abort, alert_o, alert_oe, overheat_out_n_o, overheat_out_n_oe
);
    // Open-drain pins never drive high, so shared lines stay wired-and
    chk_alert_drain: assert property (@(posedge sys_clk) disable iff (!reset_n) alert_oe |-> !alert_o)
        else $error("alert pin driven high");
    chk_ovh_drain: assert property (@(posedge sys_clk) disable iff (!reset_n) overheat_out_n_oe |-> !overheat_out_n_o)
        else $error("overheat pin driven high");
    chk_abort_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n) conv_abort |=> !conv_abort)
        else $error("abort longer than one cycle");
    // Link answers: one pulse, bounded latency, results change only with it
    chk_done_pulse: assert property (@(posedge link_clk) disable iff (!reset_n) link_done |=> !link_done)
        else $error("done longer than one cycle");
    chk_busy_answer: assert property (@(posedge link_clk) disable iff (!reset_n) $rose(link_busy) |-> ##[1:24] link_done)
        else $error("request not answered");
    chk_busy_release: assert property (@(posedge link_clk) disable iff (!reset_n)
        $fell(link_busy) |-> link_done || $past(link_done))
        else $error("busy dropped without answer");
    chk_rdata_hold: assert property (@(posedge link_clk) disable iff (!reset_n) $changed(link_rdata) |-> link_done)
        else $error("read data moved between answers");
    chk_nak_hold: assert property (@(posedge link_clk) disable iff (!reset_n) $changed(link_nak) |-> link_done)
        else $error("nak moved between answers");
endmodule
bind tsar_regs tsar_regs_chk chk (.sys_clk, .reset_n, .link_clk, .link_busy, .link_done, .link_nak, .link_rdata,
    .conv_abort, .alert_o, .alert_oe, .overheat_out_n_o, .overheat_out_n_oe);
`default_nettype wire

// ===== tsar_host.sv
// Purpose: Link-side host model, one byte transaction at a time
// Assumes: Request is taken on rising link_clk while not pending
// Notes:   Released command and data fields show inverted values so stale data never passes; kind keeps its value
`timescale 1ns/1ns
`default_nettype none
module tsar_host (
    input  wire logic link_clk,
    input  wire logic link_done,
    output logic      link_req,
    output logic [2:0] link_kind,
    output logic [7:0] link_cmd,
    output logic [7:0] link_wdata
);
    initial {link_req, link_kind, link_cmd, link_wdata} = 20'h0_0000;
    // Hold the whole request until the answer edge, bounded wait
    task automatic xfer(input logic [2:0] kind, input logic [7:0] cmd, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge link_clk);
        {link_req, link_kind, link_cmd, link_wdata} <= {1'b1, kind, cmd, wd};
        do @(posedge link_clk); while (link_done !== 1'b1 && ++n < 64);
        {link_req, link_cmd, link_wdata} <= {1'b0, ~cmd, ~wd};
    endtask
endmodule
`default_nettype wire

// ===== test_temp_sensor_alarm_regs.sv
// Purpose: Self-checking bench for the sensor register bank
// Assumes: Short conversion interval, converter stand-in answers 6 cycles after start
// Notes:   Expected alert timing comes from a fault-queue length model
`timescale 1ns/1ns
`default_nettype none
module test_temp_sensor_alarm_regs;
    logic sys_clk = 0, link_clk = 0, reset_n = 0, conv_done = 0, diode_fault = 0;
    logic [7:0] local_temp = 8'h00, remote_temp = 8'h20, link_cmd, link_wdata, link_rdata;
    logic link_req, link_busy, link_done, link_nak, conv_start, conv_abort;
    logic alert_o, alert_oe, overheat_out_n_o, overheat_out_n_oe;
    logic [2:0] link_kind;
    logic [4:0] pipe = 5'h00;
    logic [7:0] rc [10] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h19, 8'h21, 8'h22, 8'h30};
    logic [7:0] rv [10] = '{8'h00, 8'h07, 8'h55, 8'h00, 8'h5e, 8'h00, 8'h7d, 8'h0a, 8'h86, 8'h00};
    logic [7:0] fq [4] = '{8'h86, 8'h82, 8'h80, 8'h84};
    int bad_count = 0, n_tests = 0, seed = 21105;
    initial forever #10 sys_clk = ~sys_clk;
    // Link clock at 15 ns with an unrelated phase
    initial forever begin #3 link_clk = 1; #7 link_clk = 0; #5; end
    tsar_regs #(.INTERVAL_CYCLES(200)) uut (.sys_clk, .reset_n, .link_clk, .link_req, .link_kind, .link_cmd,
        .link_wdata, .link_busy, .link_done, .link_nak, .link_rdata, .conv_done, .local_temp, .local_frac(8'h00),
        .remote_temp, .remote_frac(8'h00), .diode_fault, .conv_start, .conv_abort, .alert_o, .alert_oe,
        .overheat_out_n_o, .overheat_out_n_oe);
    tsar_host host (.link_clk, .link_done, .link_req, .link_kind, .link_cmd, .link_wdata);
    // Converter stand-in, remote reading random but always in limit
    always @(posedge sys_clk) begin
        pipe <= {pipe[3:0], conv_start};
        conv_done <= pipe[4];
        if (pipe[3]) remote_temp <= 8'h10 + 8'($random(seed) & 63);
    end
    function automatic int qlen(input logic [7:0] f);
        return (f[2:1] == 2'b01) ? 2 : (f[2:1] == 2'b11) ? 3 : 1;
    endfunction
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [2:0] kind, input logic [7:0] cmd);
        host.xfer(kind, cmd, 8'h00);
    endtask
    task automatic settemp(input logic [7:0] t);
        @(posedge sys_clk) local_temp <= t;
        @(posedge conv_done);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin #400_000; bad_count++; complete_run(); end
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(tsar_pkg::KIND_RECV_BYTE, 8'h00);
        check(link_rdata, 8'h00);
        host.xfer(tsar_pkg::KIND_WRITE_BYTE, 8'h05, 8'h11);
        host.xfer(tsar_pkg::KIND_WRITE_BYTE, 8'h09, 8'h3f);
        host.xfer(tsar_pkg::KIND_WRITE_BYTE, 8'h0d, 8'h5e);
        foreach (rc[k]) begin
            rd(tsar_pkg::KIND_READ_BYTE, rc[k]);
            check(link_rdata, rv[k]);
        end
        foreach (fq[k]) begin
            settemp(8'h30);
            rd(tsar_pkg::KIND_READ_BYTE, 8'h02);
            settemp(8'h30);
            check(alert_oe, 1'b0);
            host.xfer(tsar_pkg::KIND_WRITE_BYTE, 8'h22, fq[k]);
            for (int i = 1; i < qlen(fq[k]); i++) begin
                settemp(8'h55);
                check(alert_oe, 1'b0);
            end
            settemp(8'h55);
            check({alert_oe, overheat_out_n_oe}, 2'b11);
            rd(tsar_pkg::KIND_READ_BYTE, 8'h02);
            check({link_rdata[6], alert_oe}, 2'b11);
        end
        rd(tsar_pkg::KIND_ARA, 8'h00);
        check({link_nak, link_rdata}, {1'b0, 7'h4c, 1'b1});
        settemp(8'h4b);
        check(overheat_out_n_oe, 1'b1);
        rd(tsar_pkg::KIND_ARA_OK, 8'h00);
        settemp(8'h4a);
        check({overheat_out_n_oe, alert_oe}, 2'b00);
        rd(tsar_pkg::KIND_ARA, 8'h00);
        check(link_nak, 1'b1);
        host.xfer(tsar_pkg::KIND_WRITE_BYTE, 8'h09, 8'h80);
        settemp(8'h55);
        check({alert_oe, overheat_out_n_oe}, 2'b01);
        complete_run();
    end
endmodule
`default_nettype wire
